// >>> bench/fsp_flash_model.sv
// Behavioural model of the flash device on the host's pins
`timescale 1ns/1ps
module fsp_flash_model #(
	parameter logic [15:0] MAKER_ID = 16'h1234, // arbitrary value
	parameter logic [15:0] DEV_ID   = 16'h5678, // arbitrary value
	parameter int          PROG_NS  = 3000,
	parameter int          ERASE_NS = 6000,
	parameter logic [19:0] PROT_TOP = 20'h00fff
) (
	input  wire [19:0] flashAddr,
	input  wire [15:0] dqOut,
	input  wire        chipSelectN,
	input  wire        outputGateN,
	input  wire        writeStrobeN,
	input  wire        hwResetN,
	input  wire        protectLockN,
	output wire [15:0] dqIn,
	output wire        readyBusyN
);
	logic [15:0] mem [logic [19:0]];
	logic [15:0] rd = 16'h0, opD;
	logic [19:0] opA;
	logic [14:0] a;
	logic [7:0]  d;
	logic        busy = 0, prg = 0, tog = 0;
	int          seq = 0, md = 0, gen = 0, opK = 0;
	realtime     fallT = 0;
	function automatic logic [15:0] rdm(input logic [19:0] k);
		return mem.exists(k) ? mem[k] : 16'hffff;
	endfunction
	// Completion after a delay; a reset in between cancels it
	task automatic run(input int dur);
		int g;
		g = gen;
		#dur;
		if (g == gen) begin
			if (prg)
				mem[opA] = rdm(opA) & opD;
			else foreach (mem[k])
				if ((protectLockN || k > PROT_TOP) && (opK == 3 ||
				    (opK == 1 && k[19:10] == opA[19:10]) ||
				    (opK == 2 && k[19:15] == opA[19:15])))
					mem[k] = 16'hffff;
			busy = 0;
		end
	endtask
	always @(negedge writeStrobeN) fallT = $realtime;
	// Command decoder on the strobe's rising edge; glitches are dropped
	always @(posedge writeStrobeN) begin
		a = flashAddr[14:0];
		d = dqOut[7:0];
		if (!chipSelectN && outputGateN && hwResetN && !busy &&
		    $realtime - fallT >= 5.0) begin
			case (seq)
			0, 3: seq = (a == 15'h5555 && d == 8'haa) ? seq + 1 : 0;
			1, 4: seq = (a == 15'h2aaa && d == 8'h55) ? seq + 1 : 0;
			2: begin
				seq = 0;
				if (a == 15'h5555)
					case (d)
					8'ha0: seq = 6;
					8'h80: seq = 3;
					8'h90: md = 1;
					8'h98: md = 2;
					8'hf0: md = 0;
					default: seq = 0;
					endcase
			end
			5: begin
				seq = 0;
				opA = flashAddr;
				opK = d == 8'h30 ? 1 : d == 8'h50 ? 2 :
				      (d == 8'h10 && a == 15'h5555) ? 3 : 0;
				prg = 0;
				busy = opK != 0;
				if (busy) fork run(ERASE_NS); join_none
			end
			default: begin
				seq = 0;
				opA = flashAddr;
				opD = dqOut;
				prg = 1;
				busy = protectLockN || opA > PROT_TOP;
				if (busy) fork run(PROG_NS); join_none
			end
			endcase
		end
	end
	always @(negedge hwResetN) begin
		gen++;
		busy = 0;
		seq = 0;
		md = 0;
	end
	// Read word picked when the gate falls
	always @(negedge outputGateN) if (!chipSelectN) begin
		tog = ~tog;
		if (busy)
			rd = prg ? {opD[15:8], ~opD[7], tog, opD[5:0]}
			         : {9'h0, tog, 6'h0};
		else if (md == 1)
			rd = flashAddr[0] ? DEV_ID : MAKER_ID;
		else if (md == 2)
			rd = flashAddr[7:0] == 8'h10 ? 16'h0051 : 16'h0000;
		else
			rd = rdm(flashAddr);
	end
	// Released bus shows the inverse; busy pin pulled up when released
	assign dqIn = (!chipSelectN && !outputGateN) ? rd : ~rd;
	assign readyBusyN = !(busy && !chipSelectN && hwResetN);
endmodule // fsp_flash_model

// >>> bench/fsp_host_asserts.sv
// Port checker for the flash host controller
`timescale 1ns/1ps
module fsp_host_asserts (
	input logic        clk,
	input logic        rst,
	input logic        psel,
	input logic        penable,
	input logic [11:0] paddr,
	input logic        pready,
	input logic        pslverr,
	input logic        dqOe,
	input logic        chipSelectN,
	input logic        outputGateN,
	input logic        writeStrobeN,
	input logic        hwResetN,
	input logic        protectLockN
);
	// ----------------------------------------
	// Assertions, all on the one clock
	// ----------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	AST_APB_ANSWER: assert property (psel && !penable |=> pready)
		else $error("pready missing in access cycle");
	AST_APB_PULSE: assert property (pready |=> !pready)
		else $error("pready held too long");
	AST_APB_UNMAPPED: assert property (pready && paddr > 12'h010 |-> pslverr)
		else $error("unmapped access without pslverr");
	AST_WR_INHIBIT: assert property (
		!writeStrobeN |-> !chipSelectN && outputGateN && dqOe)
		else $error("strobe low outside a clean write");
	AST_SEL_FIRST: assert property (
		$fell(writeStrobeN) |-> !$past(chipSelectN))
		else $error("strobe fell before select");
	AST_STROBE_WIDTH: assert property (
		$fell(writeStrobeN) |-> !writeStrobeN [*3])
		else $error("write strobe too short");
	AST_NO_CLASH: assert property (!outputGateN |-> !dqOe)
		else $error("host drives data while gate low");
	AST_RESET_WIDTH: assert property (
		$fell(hwResetN) |-> !hwResetN [*8] ##1 !hwResetN [*8])
		else $error("reset pulse too short");
	AST_LOCK_STABLE: assert property (
		$changed(protectLockN) |-> chipSelectN && $past(chipSelectN))
		else $error("lock level moved during a cycle");
	// Main scenarios reached
	COV_WRITE: cover property ($fell(writeStrobeN));
	COV_RESET: cover property ($fell(hwResetN));
	COV_SLVERR: cover property (pslverr);
endmodule // fsp_host_asserts

// >>> bench/fsp_host_tb_top.sv
// Self-checking bench for the flash host controller
`timescale 1ns/1ps
module fsp_host_tb_top;
	localparam logic [15:0] MAKER = 16'h1234; // arbitrary value
	localparam logic [15:0] DEVID = 16'h5678; // arbitrary value
	logic        clk = 0, rst = 1, psel = 0, penable = 0, pwrite = 0;
	logic [11:0] paddr = 0;
	logic [31:0] pwdata = 0, prdata, q, t, seed = 32'ha32b;
	logic        pready, pslverr, slv, dqOe, chipSelectN, outputGateN;
	logic        writeStrobeN, readyBusyN, hwResetN, protectLockN;
	logic [19:0] flashAddr, a, pa;
	logic [15:0] dqOut, dqIn, d, pd;
	int          miscompares = 0, check_count = 0, cyc = 0;
	fsp_host u_dut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata,
		.prdata, .pready, .pslverr, .flashAddr, .dqOut, .dqOe, .dqIn,
		.chipSelectN, .outputGateN, .writeStrobeN, .readyBusyN, .hwResetN,
		.protectLockN);
	fsp_flash_model #(.MAKER_ID(MAKER), .DEV_ID(DEVID)) u_flash (.flashAddr,
		.dqOut, .chipSelectN, .outputGateN, .writeStrobeN, .hwResetN,
		.protectLockN, .dqIn, .readyBusyN);
	// ----------------------------------------
	// Helpers
	// ----------------------------------------
	initial forever #25 clk = ~clk;
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		check_count++;
		if (g !== e) begin
			miscompares++;
			$display("mismatch at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic close_out();
		$display("checks %0d mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	// One APB transfer; read data and error taken at the pready edge
	task automatic apb(input logic w, input logic [11:0] ad,
		input logic [31:0] wd);
		@(posedge clk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= ad;
		pwdata <= wd;
		@(posedge clk);
		penable <= 1;
		do @(posedge clk); while (pready !== 1'b1);
		q = prdata;
		slv = pslverr;
		psel <= 0;
		penable <= 0;
	endtask
	// Issue one order and poll status until done; q ends as status
	task automatic op(input logic [2:0] c, input logic rn, input logic wp);
		int n;
		apb(1, 12'h004, {12'h0, a});
		apb(1, 12'h008, {16'h0, d});
		apb(1, 12'h000, {26'h0, rn, wp, c, 1'b1});
		n = 0;
		do begin
			apb(0, 12'h00c, 0);
			n++;
		end while (q[1] !== 1'b1 && n < 3000);
	endtask
	task automatic rdw();
		op(3'h7, 1, 1);
		apb(0, 12'h010, 0);
	endtask
	// Long ops still finish well inside this ceiling
	always @(posedge clk) begin
		cyc++;
		if (cyc == 60000) begin
			miscompares++;
			close_out();
		end
	end
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	initial begin
		repeat (16) @(posedge clk);
		rst <= 0;
		chk(hwResetN, 1);
		chk(protectLockN, 0);
		apb(0, 12'h014, 0);
		chk({slv, q}, {1'b1, 32'h0});
		for (int i = 0; i < 3; i++) begin
			t = xs();
			// After the first pass, erase the word written last pass so the check can trip
			a = (i == 0) ? {4'h1, t[15:0]} : pa;
			op(i == 0 ? 3'h3 : 3'(i), 1, 1);
			chk(q[3:0], 4'h6);
			rdw();
			chk(q, 32'hffff);
			a = {4'h1, t[15:0]};
			d = t[31:16];
			op(3'h0, 1, 1);
			chk(q[3:0], 4'h6);
			rdw();
			chk(q, {16'h0, d});
			pa = a;
			pd = d;
		end
		a = 0;
		op(3'h4, 1, 1);
		rdw();
		chk(q, {16'h0, MAKER});
		a = 1;
		rdw();
		chk(q, {16'h0, DEVID});
		op(3'h6, 1, 1);
		op(3'h5, 1, 1);
		a = 20'h00010;
		rdw();
		chk(q, 32'h0051);
		op(3'h6, 1, 1);
		a = pa;
		rdw();
		chk(q, {16'h0, pd});
		t = xs();
		a = 20'h00020;
		d = t[15:0] & 16'hff7f;
		op(3'h0, 1, 0);
		chk(protectLockN, 0);
		chk(q[3], 1);
		rdw();
		chk(q, 32'hffff);
		op(3'h0, 0, 1);
		chk(q[1], 1);
		a = pa;
		rdw();
		chk(q, {16'h0, pd});
		close_out();
	end
endmodule // fsp_host_tb_top
bind fsp_host fsp_host_asserts u_chk (.clk, .rst, .psel, .penable, .paddr,
	.pready, .pslverr, .dqOe, .chipSelectN, .outputGateN, .writeStrobeN,
	.hwResetN, .protectLockN);

// >>> core/fsp_bus_cycle.v
// One bus cycle on the flash pins: write or read
`timescale 1ns/1ps
`include "fsp_regs.vh"
module fsp_bus_cycle (
	input  wire        clk,
	input  wire        rst,
	input  wire        start,
	input  wire        isWrite,
	input  wire [19:0] addrIn,
	input  wire [15:0] dataIn,
	input  wire [15:0] dqIn,
	output reg         done,
	output reg  [15:0] rdData,
	output reg  [19:0] flashAddr,
	output reg  [15:0] dqOut,
	output reg         dqOe,
	output reg         chipSelectN,
	output reg         outputGateN,
	output reg         writeStrobeN
);
	localparam IDLE = 2'd0;
	localparam LOW  = 2'd1;
	localparam HIGH = 2'd2;
	reg [1:0] state_r;
	reg [3:0] cnt_r;
	reg       wr_r;
	reg [15:0] dqSync_r;
	// ----------------------------------------------------------------
	// Data pin stage
	// ----------------------------------------------------------------
	// Pins pass one stage before the capture flop, two in all
	always @(posedge clk) begin
		if (rst)
			dqSync_r <= 16'h0000;
		else
			dqSync_r <= dqIn;
	end
	// ----------------------------------------------------------------
	// Strobe sequencer
	// ----------------------------------------------------------------
	// Strobe low and high both last several clocks, far above 5 ns
	always @(posedge clk) begin
		done <= 1'b0;
		if (rst) begin
			state_r      <= IDLE;
			cnt_r        <= 4'h0;
			wr_r         <= 1'b0;
			rdData       <= 16'h0000;
			flashAddr    <= 20'h00000;
			dqOut        <= 16'h0000;
			dqOe         <= 1'b0;
			chipSelectN  <= 1'b1;
			outputGateN  <= 1'b1;
			writeStrobeN <= 1'b1;
		end else begin
			case (state_r)
			IDLE: begin
				if (start) begin
					wr_r        <= isWrite;
					flashAddr   <= addrIn;
					dqOut       <= dataIn;
					dqOe        <= isWrite;
					chipSelectN <= 1'b0;
					cnt_r       <= 4'h0;
					state_r     <= LOW;
				end
			end
			LOW: begin
				// Gate stays high during writes so writes are not inhibited
				writeStrobeN <= ~wr_r;  // RL9 RL10
				outputGateN  <= wr_r;   // RL10
				cnt_r        <= cnt_r + 4'h1;
				if (cnt_r == `FSP_STROBE_CYC + `FSP_READ_CYC) begin
					rdData       <= dqSync_r;
					writeStrobeN <= 1'b1;
					outputGateN  <= 1'b1;
					cnt_r        <= 4'h0;
					state_r      <= HIGH;
				end
			end
			HIGH: begin
				cnt_r <= cnt_r + 4'h1;
				if (cnt_r == `FSP_STROBE_CYC) begin
					chipSelectN <= 1'b1;
					dqOe        <= 1'b0;
					done        <= 1'b1;
					state_r     <= IDLE;
				end
			end
			default: state_r <= IDLE;
			endcase
		end
	end
endmodule // fsp_bus_cycle

// >>> core/fsp_host.v
// Host controller driving the flash pins from APB registers
//
// The APB slave port and the address map were chosen for this implementation.
`timescale 1ns/1ps
`include "fsp_regs.vh"
module fsp_host (
	input  wire        clk,
	input  wire        rst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output reg         pready,
	output reg         pslverr,
	output wire [19:0] flashAddr,
	output wire [15:0] dqOut,
	output wire        dqOe,
	input  wire [15:0] dqIn,
	output wire        chipSelectN,
	output wire        outputGateN,
	output wire        writeStrobeN,
	input  wire        readyBusyN,
	output reg         hwResetN,
	output reg         protectLockN
);
	localparam S_IDLE  = 3'd0;
	localparam S_SEQ   = 3'd1;
	localparam S_POLL  = 3'd2;
	localparam S_REC   = 3'd3;
	localparam S_RESET = 3'd4;
	localparam S_READ  = 3'd5;

	reg [2:0]  state_r;
	reg [2:0]  cmd_r;
	reg [19:0] addr_r;
	reg [15:0] data_r;
	reg [2:0]  step_r;
	reg [2:0]  nSteps_r;
	reg        busy_r;
	reg        done_r;
	reg        err_r;
	reg        cycGo_r;
	reg        cycWr_r;
	reg [19:0] cycAddr_r;
	reg [15:0] cycData_r;
	reg [15:0] lastRd_r;
	reg        havePrev_r;
	reg [5:0]  cnt_r;
	reg        rb1_r;
	reg        rb2_r;
	wire       cycDone;
	wire [15:0] cycRd;

	fsp_bus_cycle u_cycle (
		.clk          (clk),
		.rst          (rst),
		.start        (cycGo_r),
		.isWrite      (cycWr_r),
		.addrIn       (cycAddr_r),
		.dataIn       (cycData_r),
		.dqIn         (dqIn),
		.done         (cycDone),
		.rdData       (cycRd),
		.flashAddr    (flashAddr),
		.dqOut        (dqOut),
		.dqOe         (dqOe),
		.chipSelectN  (chipSelectN),
		.outputGateN  (outputGateN),
		.writeStrobeN (writeStrobeN)
	);

	// ----------------------------------------------------------------
	// Unlock and command table: address and low byte for each step
	// ----------------------------------------------------------------
	function [35:0] seqWord;
		input [2:0]  cmd;
		input [2:0]  step;
		input [19:0] addr;
		input [15:0] data;
		reg   [7:0]  last;
		begin
			case (cmd)
			`FSP_CMD_ID:   last = `FSP_D_90;
			`FSP_CMD_CFI:  last = `FSP_D_98;  // RL19
			`FSP_CMD_EXIT: last = `FSP_D_F0;  // RL21
			default:       last = `FSP_D_A0;
			endcase
			// Upper byte is zero in every command word
			case (step)
			3'd0, 3'd3: seqWord = {`FSP_A_5555, 8'h00, `FSP_D_AA}; // RL16 RL18
			3'd1, 3'd4: seqWord = {`FSP_A_2AAA, 8'h00, `FSP_D_55};
			3'd2: seqWord = (cmd == `FSP_CMD_SECT || cmd == `FSP_CMD_BLOCK ||
			                 cmd == `FSP_CMD_CHIP)
			                ? {`FSP_A_5555, 8'h00, `FSP_D_80}
			                : {`FSP_A_5555, 8'h00, last};
			3'd5: begin
				case (cmd)
				// Sector picked by lines 19..10, block by 19..15
				`FSP_CMD_SECT:  seqWord = {addr[19:10], 10'h000,
				                           8'h00, `FSP_D_30}; // RL22 RL23
				`FSP_CMD_BLOCK: seqWord = {addr[19:15], 15'h0000,
				                           8'h00, `FSP_D_50}; // RL23
				default:        seqWord = {`FSP_A_5555, 8'h00,
				                           `FSP_D_10};        // RL24
				endcase
			end
			default: seqWord = {addr, data};  // program word
			endcase
		end
	endfunction

	wire [35:0] nextWord = seqWord(cmd_r, step_r, addr_r, data_r);
	wire        goWr = psel && penable && pwrite &&
	                   paddr == `FSP_CTRL_OFS && pwdata[`FSP_CTRL_GO];

	// ----------------------------------------------------------------
	// Busy pin synchroniser
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			rb1_r <= 1'b1;
			rb2_r <= 1'b1;
		end else begin
			rb1_r <= readyBusyN;
			rb2_r <= rb1_r;
		end
	end

	// ----------------------------------------------------------------
	// APB slave, zero wait states
	// ----------------------------------------------------------------
	always @(posedge clk) begin
		if (rst) begin
			pready  <= 1'b0;
			pslverr <= 1'b0;
			prdata  <= 32'h00000000;
			addr_r  <= 20'h00000;
			data_r  <= 16'h0000;
		end else begin
			pready  <= psel && !penable;
			pslverr <= psel && !penable && paddr > `FSP_RDATA_OFS;
			if (psel && !penable && !pwrite) begin
				case (paddr)
				`FSP_CTRL_OFS:  prdata <= {26'h0, hwResetN, protectLockN,
				                           cmd_r, 1'b0};
				`FSP_ADDR_OFS:  prdata <= {12'h000, addr_r};
				`FSP_DATA_OFS:  prdata <= {16'h0000, data_r};
				`FSP_STAT_OFS:  prdata <= {28'h0, err_r, rb2_r,
				                           done_r, busy_r};
				`FSP_RDATA_OFS: prdata <= {16'h0000, lastRd_r};
				default:        prdata <= 32'h00000000;
				endcase
			end
			if (psel && penable && pwrite && !busy_r) begin
				if (paddr == `FSP_ADDR_OFS)
					addr_r <= pwdata[19:0];
				if (paddr == `FSP_DATA_OFS)
					data_r <= pwdata[15:0];
			end
		end
	end

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	// Completion is judged by toggle stop, never a fixed wait, since
	// the device's program and erase times vary
	always @(posedge clk) begin
		cycGo_r <= 1'b0;
		if (rst) begin
			state_r      <= S_IDLE;
			cmd_r        <= `FSP_CMD_READ;
			step_r       <= 3'd0;
			nSteps_r     <= 3'd0;
			busy_r       <= 1'b0;
			done_r       <= 1'b0;
			err_r        <= 1'b0;
			cycWr_r      <= 1'b0;
			cycAddr_r    <= 20'h00000;
			cycData_r    <= 16'h0000;
			lastRd_r     <= 16'h0000;
			havePrev_r   <= 1'b0;
			cnt_r        <= 6'd0;
			hwResetN     <= 1'b1;
			protectLockN <= 1'b0;
		end else begin
			// Done cleared by a new start; a completion in the same cycle wins
			if (goWr && !busy_r)
				done_r <= 1'b0;
			case (state_r)
			S_IDLE: begin
				if (psel && penable && pwrite && paddr == `FSP_CTRL_OFS)
					protectLockN <= pwdata[`FSP_CTRL_WPN]; // RL12
				if (goWr) begin
					cmd_r  <= pwdata[`FSP_CTRL_CMD_HI:`FSP_CTRL_CMD_LO];
					busy_r <= 1'b1;
					err_r  <= 1'b0;
					step_r <= 3'd0;
					cnt_r  <= 6'd0;
					// Reset only taken when idle, so no erase is ever cut
					if (!pwdata[`FSP_CTRL_RSTN]) begin
						hwResetN <= 1'b0;  // RL13 RL15
						state_r  <= S_RESET;
					end else begin
						case (pwdata[`FSP_CTRL_CMD_HI:`FSP_CTRL_CMD_LO])
						`FSP_CMD_PROG: nSteps_r <= 3'd4;  // RL16
						`FSP_CMD_READ: nSteps_r <= 3'd0;
						`FSP_CMD_SECT, `FSP_CMD_BLOCK,
						`FSP_CMD_CHIP: nSteps_r <= 3'd6;  // RL16
						default:       nSteps_r <= 3'd3;
						endcase
						state_r <= S_SEQ;
					end
				end
			end
			S_SEQ: begin
				if (cmd_r == `FSP_CMD_READ) begin
					cycWr_r   <= 1'b0;
					cycAddr_r <= addr_r;
					cycGo_r   <= 1'b1;
					state_r   <= S_READ;
				end else if (step_r == nSteps_r && cycDone) begin
					havePrev_r <= 1'b0;
					state_r    <= (cmd_r == `FSP_CMD_PROG ||
					    nSteps_r == 3'd6) ? S_POLL : S_IDLE;
					if (!(cmd_r == `FSP_CMD_PROG || nSteps_r == 3'd6)) begin
						busy_r <= 1'b0;
						done_r <= 1'b1;
					end
				end else if (!cycGo_r && (step_r == 3'd0 || cycDone)) begin
					// Program's fourth word follows the three-word prefix
					cycWr_r   <= 1'b1;
					cycAddr_r <= (cmd_r == `FSP_CMD_PROG && step_r == 3'd3)
					             ? addr_r : nextWord[35:16];
					cycData_r <= (cmd_r == `FSP_CMD_PROG && step_r == 3'd3)
					             ? data_r : nextWord[15:0];
					cycGo_r   <= 1'b1;
					step_r    <= step_r + 3'd1;
				end else if (cycDone && step_r == 3'd0) begin
					step_r <= step_r;
				end
				if (cycDone && step_r == nSteps_r - 3'd1)
					step_r <= nSteps_r;
				else if (cycGo_r || (!cycDone && step_r != 3'd0))
					step_r <= step_r;
			end
			S_POLL: begin
				// Toggle checks start only after the last write pulse
				if (!cycGo_r && (cycDone || !havePrev_r && cnt_r == 6'd0)) begin
					if (cycDone) begin
						havePrev_r <= 1'b1;
						lastRd_r   <= cycRd;
						if (havePrev_r && cycRd[6] == lastRd_r[6]) begin
							// Bit 6 stopped; bit 7 tells failure
							err_r   <= (cmd_r == `FSP_CMD_PROG)
							           ? (cycRd[7] != data_r[7])
							           : !cycRd[7];  // RL4 RL5 RL7 RL8
							cnt_r   <= 6'd0;
							state_r <= S_REC;
						end else begin
							cycGo_r <= 1'b1;
						end
					end else begin
						cnt_r   <= 6'd1;
						cycWr_r <= 1'b0;
						cycGo_r <= 1'b1;  // RL6
					end
				end
			end
			S_REC: begin
				cnt_r <= cnt_r + 6'd1;
				if (cnt_r == `FSP_TBR_CYC) begin  // RL3
					busy_r  <= 1'b0;
					done_r  <= 1'b1;
					state_r <= S_IDLE;
				end
			end
			S_RESET: begin
				cnt_r <= cnt_r + 6'd1;
				if (cnt_r == `FSP_RST_CYC)
					hwResetN <= 1'b1;
				if (cnt_r == `FSP_RST_CYC + `FSP_TBR_CYC) begin  // RL14
					busy_r  <= 1'b0;
					done_r  <= 1'b1;
					state_r <= S_IDLE;
				end
			end
			S_READ: begin
				if (cycDone) begin
					lastRd_r <= cycRd;
					busy_r   <= 1'b0;
					done_r   <= 1'b1;
					state_r  <= S_IDLE;
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end
endmodule // fsp_host

// >>> pkg/fsp_regs.vh
// Constants for the flash status and protection controller
// Notes on behaviour
// RL1: Device holds ready_busy_n low while program or erase runs internally.
// RL2: ready_busy_n floats while chip select high or hardware reset low.
// RL3: Host waits bus_recovery_time of 1 us after completion before reading.
// RL4: During program, bit 7 reads inverted data; true data afterwards.
// RL5: During erase, bit 7 reads 0; after erase it reads 1.
// RL6: Polling valid after fourth write pulse (program), sixth (erase).
// RL7: Bit 6 toggles on consecutive reads while busy; stops when done.
// RL8: Toggle valid after fourth or sixth pulse; host resumes when stable.
// RL9: Strobe pulses shorter than 5 ns never start a write cycle.
// RL10: Writes inhibited when output gate low, select high or strobe high.
// RL11: protect_lock_n low blocks altering outer 4 KWord of larger bank.
// RL12: Host raises protect_lock_n before command, holds it until done.
// RL13: Reset low for reset_pulse_min aborts operation, returns to read.
// RL14: Host waits reset_to_read_delay after reset release before reading.
// RL15: Host reissues an erase that reset interrupted.
// RL16: Program needs three-cycle unlock prefix; erase needs six cycles.
// RL17: Invalid word mid-sequence aborts to read within read_cycle_time.
// RL18: Command decoded from low byte only; bits 15..8 ignored.
// RL19: Query mode entered by three cycles ending 98H at 5555H.
// RL20: ID mode: word 0000H gives maker code, 0001H device code.
// RL21: Exit command returns to read; ignored while device busy.
// RL22: Sector erase uses address lines 19..10; data floats when deselected.
// RL23: Sector erase ends 30H at sector; block erase ends 50H at block.
// RL24: Chip erase ends 10H at 5555H, erasing unprotected area to ones.
// RL25: Program and erase durations are delays, not fixed times.
`ifndef FSP_REGS_VH
`define FSP_REGS_VH
// ----------------------------------------------------------------
// APB register map
// ----------------------------------------------------------------
`define FSP_CTRL_OFS     12'h000
`define FSP_ADDR_OFS     12'h004
`define FSP_DATA_OFS     12'h008
`define FSP_STAT_OFS     12'h00c
`define FSP_RDATA_OFS    12'h010
// CTRL fields
`define FSP_CTRL_GO      0
`define FSP_CTRL_CMD_LO  1
`define FSP_CTRL_CMD_HI  3
`define FSP_CTRL_WPN     4
`define FSP_CTRL_RSTN    5
// Commands
`define FSP_CMD_PROG     3'h0
`define FSP_CMD_SECT     3'h1
`define FSP_CMD_BLOCK    3'h2
`define FSP_CMD_CHIP     3'h3
`define FSP_CMD_ID       3'h4
`define FSP_CMD_CFI      3'h5
`define FSP_CMD_EXIT     3'h6
`define FSP_CMD_READ     3'h7
// STAT fields
`define FSP_STAT_BUSY    0
`define FSP_STAT_DONE    1
`define FSP_STAT_RDYPIN  2
`define FSP_STAT_ERR     3
// ----------------------------------------------------------------
// Flash command words
// ----------------------------------------------------------------
`define FSP_A_5555       20'h05555
`define FSP_A_2AAA       20'h02aaa
`define FSP_D_AA         8'haa
`define FSP_D_55         8'h55
`define FSP_D_A0         8'ha0
`define FSP_D_80         8'h80
`define FSP_D_90         8'h90
`define FSP_D_98         8'h98
`define FSP_D_F0         8'hf0
`define FSP_D_30         8'h30
`define FSP_D_50         8'h50
`define FSP_D_10         8'h10
// ----------------------------------------------------------------
// Timing, 50 ns clock
// ----------------------------------------------------------------
`define FSP_CLK_NS       50
`define FSP_TBR_NS       1000
`define FSP_TBR_CYC      ((`FSP_TBR_NS + `FSP_CLK_NS - 1) / `FSP_CLK_NS)
`define FSP_STROBE_CYC   2
`define FSP_RST_CYC      16
`define FSP_READ_CYC     2
`endif
